// File: src/csr_pkg.sv
// Notes on behaviour
// - Readable, writable 8-bit control register selects mode
// - External clock edges after completion set overrun, no shifting
// - 16-bit: upper register shifts into lower register
// - 8-bit: lower register out LSB first, in MSB
// - Eight internal clocks or external; pin direction follows
// - Continuous mode keeps internal clock running on pin
// - Word lengths of 8, 12 and 16 bits, LSB first
// - Output changes on falling edge, input sampled rising
// - Completion sets interrupt flag; enable gates request
// - Mode bits 7 and 6 zero: 8-bit mode
// - Tail mark bit 5 zero: no tail mark
// - Clock source bit 3 set: external clock pin
// - Overrun in status bit 5; zero write clears
// - Writing start bit 0 begins; cleared at completion
// - Received 8-bit word is read from lower register
// - Interrupt enable at bit 4 of enable register
// - Port function: bit 1 data, bit 0 clock
package csr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] CSR_IDX_CTRL = 16'hffa0;
	localparam logic [15:0] CSR_IDX_STAT = 16'hffa1;
	localparam logic [15:0] CSR_IDX_DHI = 16'hffa2;
	localparam logic [15:0] CSR_IDX_DLO = 16'hffa3;
	localparam logic [15:0] CSR_IDX_IEN = 16'hfff5;
	localparam logic [15:0] CSR_IDX_IRQ = 16'hfff8;
	localparam logic [15:0] CSR_IDX_PFN = 16'hfffd;
	localparam int CSR_AW = 18;

	// Control register fields
	localparam int CSR_CTRL_MODE_LSB = 6;
	localparam int CSR_CTRL_TAIL = 5;
	localparam int CSR_CTRL_CKSRC = 3;
	localparam int CSR_CTRL_PSC_LSB = 0;

	// Status register fields
	localparam int CSR_STAT_EXT = 6;
	localparam int CSR_STAT_OVR = 5;
	localparam int CSR_STAT_START = 0;

	// Interrupt and port function fields
	localparam int CSR_IRQ_BIT = 4;
	localparam int CSR_PFN_SO = 2;
	localparam int CSR_PFN_SI = 1;
	localparam int CSR_PFN_SCK = 0;

	// Transfer modes held in control bits 7:6
	localparam logic [1:0] CSR_MODE_8 = 2'h0;
	localparam logic [1:0] CSR_MODE_16 = 2'h1;
	localparam logic [1:0] CSR_MODE_CONT = 2'h2;
	localparam logic [1:0] CSR_MODE_12 = 2'h3;

	// Word lengths in bits
	localparam logic [4:0] CSR_LEN_8 = 5'h08;
	localparam logic [4:0] CSR_LEN_12 = 5'h0c;
	localparam logic [4:0] CSR_LEN_16 = 5'h10;

	// Values after reset
	localparam logic [7:0] CSR_CTRL_RST = 8'h00;
	localparam logic [7:0] CSR_DATA_RST = 8'h00;
	localparam logic [2:0] CSR_PFN_RST = 3'h0;

	// Prescaler: half period of internal clock is base shifted by select
	localparam int CSR_PSC_W = 9;
	localparam logic [8:0] CSR_PSC_BASE_HALF = 9'h002;

	// AXI responses
	localparam logic [1:0] CSR_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;

endpackage

// File: src/csr_prescaler.sv
`timescale 1ns/1ps
module csr_prescaler
	import csr_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic run_in,
	input wire logic [2:0] sel_in,
	output logic tick_out
);

	typedef struct packed
	{
		logic [CSR_PSC_W-1:0] cnt;
		logic tick;
	} csr_psc_t;

	csr_psc_t s;
	csr_psc_t next_s;
	logic [CSR_PSC_W-1:0] half;

	////////////////////////////////////////////////////////////////////////
	// One of eight divide ratios; counter held at zero while stopped
	always_comb
	begin
		next_s = s;
		half = CSR_PSC_BASE_HALF << sel_in;
		next_s.tick = 1'b0;
		if (!run_in)
		begin
			next_s.cnt = '0;
		end
		else if (s.cnt == half - 9'h001)
		begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end
		else
		begin
			next_s.cnt = s.cnt + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s <= '0;
		end
		else if (ce_in)
		begin
			s <= next_s;
		end
	end

	assign tick_out = s.tick;

endmodule // csr_prescaler

// File: src/csr_top.sv
`timescale 1ns/1ps
module csr_top
	import csr_pkg::*;
(
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic CE_IN,
	input wire logic [CSR_AW-1:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [CSR_AW-1:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	input wire logic SI_IN,
	output logic SO_OUT,
	output logic SO_OE_OUT,
	output logic IRQ_OUT
);

	typedef enum logic [1:0]
	{
		CSR_XF_IDLE = 2'b01,
		CSR_XF_SHIFT = 2'b10
	} csr_xfer_t;

	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic have_aw;
		logic have_w;
		logic [15:0] waddr;
		logic [7:0] wdata;
		logic wlane;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] ctrl;
		logic [7:0] dhi;
		logic [7:0] dlo;
		logic ien;
		logic [2:0] pfn;
		logic start;
		logic ovr;
		logic ext;
		logic irqf;
		logic done_seen;
		csr_xfer_t xf;
		logic [4:0] bits;
		logic sck_prev;
		logic sck_int;
		logic so;
		logic sck_oe;
		logic so_oe;
		logic irq;
	} csr_state_t;

	csr_state_t s;
	csr_state_t next_s;
	logic tick;
	logic run_int;

	////////////////////////////////////////////////////////////////////////
	// Address decode, shared by the read and write paths
	function automatic logic reg_known(input logic [15:0] idx);
		reg_known = (idx == CSR_IDX_CTRL) || (idx == CSR_IDX_STAT) ||
			(idx == CSR_IDX_DHI) || (idx == CSR_IDX_DLO) ||
			(idx == CSR_IDX_IEN) || (idx == CSR_IDX_IRQ) ||
			(idx == CSR_IDX_PFN);
	endfunction

	// Read value of one register; unused bits read as zero
	function automatic logic [7:0] reg_value(input logic [15:0] idx,
		input csr_state_t st);
		logic [7:0] v;
		v = 8'h00;
		if (idx == CSR_IDX_CTRL)
			v = st.ctrl;
		else if (idx == CSR_IDX_STAT)
			v = {1'b0, st.ext, st.ovr, 4'h0, st.start};
		else if (idx == CSR_IDX_DHI)
			v = st.dhi;
		else if (idx == CSR_IDX_DLO)
			v = st.dlo;
		else if (idx == CSR_IDX_IEN)
			v = {3'h0, st.ien, 4'h0};
		else if (idx == CSR_IDX_IRQ)
			v = {3'h0, st.irqf, 4'h0};
		else if (idx == CSR_IDX_PFN)
			v = {5'h00, st.pfn};
		reg_value = v;
	endfunction

	// Bit count of one word for each mode
	function automatic logic [4:0] word_len(input logic [1:0] mode);
		logic [4:0] n;
		n = CSR_LEN_8;
		if (mode == CSR_MODE_16)
			n = CSR_LEN_16;
		else if (mode == CSR_MODE_12)
			n = CSR_LEN_12;
		word_len = n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Internal transfer clock source
	csr_prescaler u_prescaler
	(
		.clk_in(REF_CLK_IN),
		.rst_n_in(ARST_N_IN),
		.ce_in(CE_IN),
		.run_in(run_int),
		.sel_in(s.ctrl[CSR_CTRL_PSC_LSB +: 3]),
		.tick_out(tick)
	);

	// When selected by bit 3 clear, internal clock runs during a transfer, or always in continuous mode
	assign run_int = !s.ctrl[CSR_CTRL_CKSRC] &&
		((s.xf == CSR_XF_SHIFT) ||
		(s.ctrl[CSR_CTRL_MODE_LSB +: 2] == CSR_MODE_CONT));

	////////////////////////////////////////////////////////////////////////
	// Next state: bus slave first, then the shifter, so that hardware
	// events land after software writes and win over a clear
	always_comb
	begin
		logic ext_clk;
		logic sck_now;
		logic si;
		logic rise;
		logic fall;
		logic do_wr;
		logic [1:0] mode;
		logic [4:0] bits_inc;
		ext_clk = 1'b0;
		sck_now = 1'b1;
		si = 1'b1;
		rise = 1'b0;
		fall = 1'b0;
		do_wr = 1'b0;
		mode = 2'h0;
		bits_inc = 5'h00;
		next_s = s;

		// Write address and data are taken in either order
		if (S_AXI_AWVALID_IN && s.awready)
		begin
			next_s.have_aw = 1'b1;
			next_s.waddr = S_AXI_AWADDR_IN[CSR_AW-1:2];
		end
		if (S_AXI_WVALID_IN && s.wready)
		begin
			next_s.have_w = 1'b1;
			next_s.wdata = S_AXI_WDATA_IN[7:0];
			next_s.wlane = S_AXI_WSTRB_IN[0];
		end
		if (s.bvalid && S_AXI_BREADY_IN)
		begin
			next_s.bvalid = 1'b0;
		end

		// Perform the write once both halves are held
		do_wr = s.have_aw && s.have_w && !s.bvalid;
		if (do_wr)
		begin
			next_s.have_aw = 1'b0;
			next_s.have_w = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = reg_known(s.waddr) ? CSR_RESP_OKAY :
				CSR_RESP_SLVERR;
		end
		if (do_wr && s.wlane)
		begin
			if (s.waddr == CSR_IDX_CTRL)
			begin
				next_s.ctrl = s.wdata;
			end
			else if (s.waddr == CSR_IDX_STAT)
			begin
				next_s.ext = s.wdata[CSR_STAT_EXT];
				if (!s.wdata[CSR_STAT_OVR])
					next_s.ovr = 1'b0;
				if (s.wdata[CSR_STAT_START] && s.xf == CSR_XF_IDLE)
				begin
					next_s.start = 1'b1;
					next_s.xf = CSR_XF_SHIFT;
					next_s.bits = 5'h00;
					next_s.done_seen = 1'b0;
				end
			end
			else if (s.waddr == CSR_IDX_DHI)
				next_s.dhi = s.wdata;
			else if (s.waddr == CSR_IDX_DLO)
				next_s.dlo = s.wdata;
			else if (s.waddr == CSR_IDX_IEN)
				next_s.ien = s.wdata[CSR_IRQ_BIT];
			else if (s.waddr == CSR_IDX_IRQ)
			begin
				if (s.wdata[CSR_IRQ_BIT])
					next_s.irqf = 1'b0;
			end
			else if (s.waddr == CSR_IDX_PFN)
				next_s.pfn = s.wdata[2:0];
		end

		// Read path: one word in flight, data from a register
		if (s.rvalid && S_AXI_RREADY_IN)
		begin
			next_s.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_IN && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rdata = {24'h000000,
				reg_value(S_AXI_ARADDR_IN[CSR_AW-1:2], s)};
			next_s.rresp = reg_known(S_AXI_ARADDR_IN[CSR_AW-1:2]) ?
				CSR_RESP_OKAY : CSR_RESP_SLVERR;
		end

		// Clock source and pin routing
		ext_clk = s.ctrl[CSR_CTRL_CKSRC];
		if (ext_clk)
			sck_now = s.pfn[CSR_PFN_SCK] ? SCK_IN : 1'b1;
		else
			sck_now = s.sck_int;
		si = s.pfn[CSR_PFN_SI] ? SI_IN : 1'b1;
		next_s.sck_prev = sck_now;
		rise = !s.sck_prev && sck_now;
		fall = s.sck_prev && !sck_now;

		// Internal clock idles high and toggles on each prescaler tick
		if (!run_int)
			next_s.sck_int = 1'b1;
		else if (tick)
			next_s.sck_int = !s.sck_int;

		// Shifter; tail mark is never sent, whatever bit 5 says
		mode = s.ctrl[CSR_CTRL_MODE_LSB +: 2];
		bits_inc = s.bits + 5'h01;
		unique case (s.xf)
			CSR_XF_SHIFT:
			begin
				if (fall)
					next_s.so = s.dlo[0];
				if (rise)
				begin
					// Sample on the rising edge, LSB first
					if (mode == CSR_MODE_8 || mode == CSR_MODE_CONT)
					begin
						next_s.dlo = {si, s.dlo[7:1]};
					end
					else
					begin
						next_s.dhi = {si, s.dhi[7:1]};
						next_s.dlo = {s.dhi[0], s.dlo[7:1]};
					end
					next_s.bits = bits_inc;
					if (bits_inc == word_len(mode))
					begin
						next_s.xf = CSR_XF_IDLE;
						next_s.start = 1'b0;
						next_s.irqf = 1'b1;
						next_s.done_seen = 1'b1;
					end
				end
			end
			CSR_XF_IDLE:
			begin
				// Extra clocks after a finished word are not shifted in
				if (rise && ext_clk && s.done_seen)
					next_s.ovr = 1'b1;
			end
		endcase

		// Registered outputs
		next_s.awready = !next_s.have_aw && !next_s.bvalid;
		next_s.wready = !next_s.have_w && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
		next_s.sck_oe = next_s.pfn[CSR_PFN_SCK] &&
			!next_s.ctrl[CSR_CTRL_CKSRC];
		next_s.so_oe = next_s.pfn[CSR_PFN_SO];
		next_s.irq = next_s.irqf && next_s.ien;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; clock enable freezes everything
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.ctrl <= CSR_CTRL_RST;
			s.dhi <= CSR_DATA_RST;
			s.dlo <= CSR_DATA_RST;
			s.pfn <= CSR_PFN_RST;
			s.xf <= CSR_XF_IDLE;
			s.sck_prev <= 1'b1;
			s.sck_int <= 1'b1;
		end
		else if (CE_IN)
		begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port mapping, all straight from flip-flops
	assign S_AXI_AWREADY_OUT = s.awready;
	assign S_AXI_WREADY_OUT = s.wready;
	assign S_AXI_BRESP_OUT = s.bresp;
	assign S_AXI_BVALID_OUT = s.bvalid;
	assign S_AXI_ARREADY_OUT = s.arready;
	assign S_AXI_RDATA_OUT = s.rdata;
	assign S_AXI_RRESP_OUT = s.rresp;
	assign S_AXI_RVALID_OUT = s.rvalid;
	assign SCK_OUT = s.sck_int;
	assign SCK_OE_OUT = s.sck_oe;
	assign SO_OUT = s.so;
	assign SO_OE_OUT = s.so_oe;
	assign IRQ_OUT = s.irq;

endmodule // csr_top

// File: tb/csr_chk.sv
`timescale 1ns/1ps
module csr_chk
	import csr_pkg::*;
(
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic S_AXI_AWVALID_IN,
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_WVALID_IN,
	input wire logic S_AXI_WREADY_OUT,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [CSR_AW-1:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic [1:0] S_AXI_RRESP_OUT,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN
);
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);
	logic [1:0] ar_e;

	// Only the seven known indices answer OKAY
	function automatic logic [1:0] rsp(logic [CSR_AW-1:0] a);
		return a[17:2] inside {CSR_IDX_CTRL, CSR_IDX_STAT, CSR_IDX_DHI,
			CSR_IDX_DLO, CSR_IDX_IEN, CSR_IDX_IRQ, CSR_IDX_PFN} ?
			CSR_RESP_OKAY : CSR_RESP_SLVERR;
	endfunction

	// Expected read response, latched when the address is taken
	always_ff @(posedge REF_CLK_IN)
	begin
		if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
			ar_e <= rsp(S_AXI_ARADDR_IN);
	end

	////////////////////////////////////////
	a_rresp_map: assert property (
		S_AXI_RVALID_OUT |-> S_AXI_RRESP_OUT == ar_e)
		else $error("read response does not match address");
	a_rdata_byte: assert property (
		S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	a_bad_zero: assert property (S_AXI_RVALID_OUT &&
		S_AXI_RRESP_OUT == CSR_RESP_SLVERR |->
		S_AXI_RDATA_OUT == 32'h00000000)
		else $error("unmapped read returned data");
	a_read_lat: assert property (S_AXI_ARVALID_IN &&
		S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
		else $error("read answer late");
	a_write_lat: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
		&& S_AXI_WVALID_IN && S_AXI_WREADY_OUT
		|=> !S_AXI_BVALID_OUT ##1 S_AXI_BVALID_OUT)
		else $error("write answer not two edges after take");
	a_r_done: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN
		|=> !S_AXI_RVALID_OUT && S_AXI_ARREADY_OUT)
		else $error("read channel not freed");
	a_b_done: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN
		|=> !S_AXI_BVALID_OUT && S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT)
		else $error("write channel not freed");
	a_ar_block: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
		else $error("address taken while read pending");
	a_aw_block: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT)
		else $error("address taken while write pending");
endmodule // csr_chk

bind csr_top csr_chk u_chk (.*);

// File: tb/csr_xmit.sv
`timescale 1ns/1ps
module csr_xmit
(
	input wire logic clk_in,
	input wire logic so_in,
	output logic sck_out,
	output logic si_out,
	output logic [15:0] so_word_out
);
	// Clock idles high between frames
	initial
	begin
		sck_out = 1'b1;
		si_out = 1'b0;
		so_word_out = 16'h0000;
	end

	// One word LSB first; slow phases leave room for pin sampling
	task automatic frame(input int n, input logic [15:0] d);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_in);
			sck_out <= 1'b0;
			repeat (2) @(posedge clk_in);
			si_out <= d[i];
			repeat (3) @(posedge clk_in);
			so_word_out <= {so_in, so_word_out[15:1]};
			sck_out <= 1'b1;
			repeat (3) @(posedge clk_in);
		end
		// Hold time over: the line stops showing the last bit
		si_out <= ~si_out;
	endtask
endmodule // csr_xmit

// File: tb/test_clocked_serial_receiver.sv
`timescale 1ns/1ps
module test_clocked_serial_receiver
	import csr_pkg::*;
;
	logic clk, rst_n, awv, wv, bry, arv, rry, sck_pin, so_pin;
	logic [CSR_AW-1:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [1:0] bre, rre, wresp;
	logic bv, rv, awr, wr_r, arr, sck_o, sck_oe, so_o, so_oe, irq, xsck, xsi;
	logic [15:0] so_w;
	logic ce;
	int err_total, samples_checked;

	csr_top DUT (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
		.S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wr_r), .S_AXI_BRESP_OUT(bre),
		.S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
		.S_AXI_RRESP_OUT(rre), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rry), .SCK_IN(sck_pin), .SCK_OUT(sck_o),
		.SCK_OE_OUT(sck_oe), .SI_IN(xsi), .SO_OUT(so_o),
		.SO_OE_OUT(so_oe), .IRQ_OUT(irq));
	csr_xmit xm (.clk_in(clk), .so_in(so_pin), .sck_out(xsck),
		.si_out(xsi), .so_word_out(so_w));
	// Pin levels from whoever drives; idle data pin pulled high
	assign sck_pin = sck_oe ? sck_o : xsck;
	assign so_pin = so_oe ? so_o : 1'b1;

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	// Both write channels offered together, each dropped when taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic b;
		b = 1'b0;
		awa <= {a, 2'h0};
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!b)
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr_r)
				wv <= 1'b0;
			b = bv;
		end
		wresp = bre;
		bry <= 1'b0;
		@(posedge clk);
	endtask

	// Read one register; expected value is {response, byte}
	task automatic rc(input logic [15:0] a, input logic [9:0] e);
		logic b;
		b = 1'b0;
		ara <= {a, 2'h0};
		arv <= 1'b1;
		rry <= 1'b1;
		while (!b)
		begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
			b = rv;
		end
		cmp({6'h00, rre, rdat[7:0]}, {6'h00, e});
		rry <= 1'b0;
		@(posedge clk);
	endtask

	// Count level changes of the driven clock pin over c cycles
	task automatic tgl(input int c, output int n);
		logic pv;
		n = 0;
		pv = sck_o;
		repeat (c)
		begin
			@(posedge clk);
			n += int'(sck_o != pv);
			pv = sck_o;
		end
	endtask

	////////////////////////////////////////
	task automatic t_regs;
		rc(CSR_IDX_CTRL, {2'h0, CSR_CTRL_RST});
		rc(CSR_IDX_DLO, {2'h0, CSR_DATA_RST});
		rc(CSR_IDX_STAT, 10'h000);
		wr(CSR_IDX_CTRL, 8'ha7);
		rc(CSR_IDX_CTRL, 10'h0a7);
		rc(16'hffa4, 10'h200);
		wr(16'hffa4, 8'h55);
		cmp(16'(wresp), 16'(CSR_RESP_SLVERR));
		$display("done regs");
	endtask

	task automatic t_ext8;
		wr(CSR_IDX_PFN, 8'h07);
		wr(CSR_IDX_CTRL, 8'h08);
		wr(CSR_IDX_DLO, 8'h3c);
		wr(CSR_IDX_IEN, 8'h10);
		wr(CSR_IDX_STAT, 8'h01);
		rc(CSR_IDX_STAT, 10'h001);
		cmp(16'(sck_oe), 16'h0000);
		xm.frame(8, 16'h00a5);
		rc(CSR_IDX_STAT, 10'h000);
		cmp(16'(irq), 16'h0001);
		rc(CSR_IDX_DLO, 10'h0a5);
		cmp(so_w >> 8, 16'h003c);
		wr(CSR_IDX_IRQ, 8'h10);
		cmp(16'(irq), 16'h0000);
		// Edges with no transfer armed must not shift
		xm.frame(2, 16'h0000);
		rc(CSR_IDX_STAT, 10'h020);
		rc(CSR_IDX_DLO, 10'h0a5);
		// Data pin keeps the last data bit; no tail mark follows
		cmp(16'(so_o), 16'h0000);
		wr(CSR_IDX_STAT, 8'h00);
		rc(CSR_IDX_STAT, 10'h000);
		$display("done external 8");
	endtask

	task automatic t_wide(input logic [7:0] c, input int n,
		input logic [15:0] d, input logic [7:0] el, input logic [7:0] eh,
		input int sh, input logic [15:0] eso);
		wr(CSR_IDX_CTRL, c);
		wr(CSR_IDX_DHI, 8'h12);
		wr(CSR_IDX_DLO, 8'h34);
		wr(CSR_IDX_IEN, 8'h00);
		wr(CSR_IDX_STAT, 8'h01);
		xm.frame(n, d);
		rc(CSR_IDX_DLO, {2'h0, el});
		rc(CSR_IDX_DHI, {2'h0, eh});
		cmp(so_w >> sh, eso);
		rc(CSR_IDX_IRQ, 10'h010);
		cmp(16'(irq), 16'h0000);
		wr(CSR_IDX_IRQ, 8'h10);
		$display("done wide %0d", n);
	endtask

	task automatic t_int;
		int n;
		logic pv;
		wr(CSR_IDX_CTRL, 8'h00);
		wr(CSR_IDX_PFN, 8'h00);
		cmp(16'(sck_oe), 16'h0000);
		wr(CSR_IDX_PFN, 8'h01);
		wr(CSR_IDX_IEN, 8'h10);
		cmp(16'(sck_oe), 16'h0001);
		wr(CSR_IDX_STAT, 8'h01);
		n = 0;
		pv = sck_o;
		// Count clock rises well past completion
		repeat (80)
		begin
			@(posedge clk);
			n += int'(sck_o && !pv);
			pv = sck_o;
		end
		cmp(16'(n), 16'h0008);
		cmp(16'(irq), 16'h0001);
		rc(CSR_IDX_DLO, 10'h0ff);
		wr(CSR_IDX_CTRL, 8'h80);
		n = 0;
		repeat (40)
		begin
			@(posedge clk);
			n += int'(sck_o != pv);
			pv = sck_o;
		end
		cmp(16'(n > 10), 16'h0001);
		// Select two: half period of eight cycles, about five toggles
		wr(CSR_IDX_CTRL, 8'h82);
		tgl(40, n);
		cmp(16'(n >= 4 && n <= 6), 16'h0001);
		// Clock enable low must freeze the running clock
		ce <= 1'b0;
		@(posedge clk);
		tgl(20, n);
		cmp(16'(n), 16'h0000);
		ce <= 1'b1;
		$display("done internal");
	endtask

	task automatic test_done;
		$display("checks %0d bad %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		{awv, wv, bry, arv, rry} = 5'h00;
		ce = 1'b1;
		awa = '0;
		ara = '0;
		wd = 32'h00000000;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_ext8;
		t_wide(8'h48, 16, 16'hbeef, 8'hef, 8'hbe, 0, 16'h1234);
		t_wide(8'hc8, 12, 16'h0abc, 8'hc1, 8'hab, 4, 16'h0234);
		t_int;
		test_done;
	end

	// Whole run needs under a thousand cycles; cut a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		test_done;
	end
endmodule // test_clocked_serial_receiver
